// file: rtl/deframer_pkg.sv
package deframer_pkg;

	localparam int unsigned SAMPLE_W   = 32;
	localparam int unsigned USB_W      = 24;
	localparam int unsigned SRC_W      = 5;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned FIFO_DEPTH = 8;

	// stream rates; one 16 kHz slot spans this many 48 kHz frames
	localparam int unsigned RATE_IN_HZ  = 48000;
	localparam int unsigned RATE_OUT_HZ = 16000;
	localparam logic [1:0]  LAST_PHASE  = 2'((RATE_IN_HZ / RATE_OUT_HZ) - 1);

	// crossbar sources
	localparam logic [SRC_W-1:0] SRC_USB_PACKED = 5'h11;
	localparam logic [SRC_W-1:0] SRC_I2S_PACKED = 5'h12;

	// register map
	localparam logic [ADDR_W-1:0] ADDR_ROUTE  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [31:0]       ROUTE_RST   = 32'h0000_0000;
	localparam int unsigned ROUTE_LANE_W    = 8;
	localparam int unsigned ST_RES24_BIT    = 0;
	localparam int unsigned ST_LOCK_BIT     = 1;
	localparam int unsigned ST_MUTE_BIT     = 2;
	localparam int unsigned ST_TWO_CH_BIT   = 3;
	localparam int unsigned ST_ERRCNT_LSB   = 8;
	localparam int unsigned ERRCNT_W        = 8;

	// marker bit position inside a left-justified 32-bit word
	localparam logic [4:0] MARK_POS_USB24 = 5'h08;
	localparam logic [4:0] MARK_POS_USB16 = 5'h10;
	localparam logic [4:0] MARK_POS_I2S   = 5'h00;

	// marker pairs {left, right} per frame phase
	localparam logic [1:0] MARK_START = 2'b11;
	localparam logic [1:0] MARK_MID   = 2'b00;

	typedef struct packed {
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
		logic                mark_l;
		logic                mark_r;
	} frame_t;

	typedef struct packed {
		logic [SAMPLE_W-1:0] mic_a;
		logic [SAMPLE_W-1:0] mic_b;
		logic [SAMPLE_W-1:0] ref_a;
		logic [SAMPLE_W-1:0] ref_b;
	} quad_t;

	typedef enum logic [1:0] {
		ST_HUNT  = 2'b00,
		ST_ALIGN = 2'b01,
		ST_RUN   = 2'b11
	} sync_state_t;

endpackage

// file: rtl/frame_fifo.sv
module frame_fifo #(
	parameter int unsigned WIDTH = 66,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// honest flags straight from the fill count
	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];

	// storage has no reset; only the pointers and the fill count need a defined value
	always_ff @(posedge hclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// file: rtl/packed_audio_injection_deframer.sv
module packed_audio_injection_deframer
	import deframer_pkg::*;
(
	// clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// ahb-lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	// stored configuration, sampled once after reset
	input  wire logic                cfg_usb_res24,
	// usb packed stream, 48 kHz stereo
	input  wire logic                usb_valid,
	output logic                     usb_ready,
	input  wire logic [USB_W-1:0]    usb_left,
	input  wire logic [USB_W-1:0]    usb_right,
	// i2s packed stream, 48 kHz stereo
	input  wire logic                i2s_valid,
	output logic                     i2s_ready,
	input  wire logic [SAMPLE_W-1:0] i2s_left,
	input  wire logic [SAMPLE_W-1:0] i2s_right,
	// live microphones and reference, 16 kHz
	input  wire logic                live_valid,
	output logic                     live_ready,
	input  wire quad_t               live_in,
	// pipeline front end, 16 kHz
	output logic                     pipe_valid,
	input  wire logic                pipe_ready,
	output logic [SAMPLE_W-1:0]      pipeline_mic_input_a,
	output logic [SAMPLE_W-1:0]      pipeline_mic_input_b,
	output logic [SAMPLE_W-1:0]      pipeline_ref_input_a,
	output logic [SAMPLE_W-1:0]      pipeline_ref_input_b
);

	// clears the marker bit and everything below it
	function automatic logic [SAMPLE_W-1:0] strip(input logic [SAMPLE_W-1:0] w,
		input logic [4:0] pos);
		logic [SAMPLE_W-1:0] m;
		m = 32'hFFFF_FFFF << (6'(pos) + 6'h01);
		return w & m;
	endfunction

	// left-justifies a usb word according to the start-up resolution
	function automatic logic [SAMPLE_W-1:0] usb_word(input logic [USB_W-1:0] w,
		input logic r24);
		return r24 ? {w, 8'h00} : {w[23:8], 16'h0000};
	endfunction

	// picks one destination's value; unmatched packed sources stay silent
	function automatic logic [SAMPLE_W-1:0] pick(input logic [SRC_W-1:0] sel,
		input logic [SRC_W-1:0] act, input logic mute,
		input logic [SAMPLE_W-1:0] pk, input logic [SAMPLE_W-1:0] lv);
		if (sel == SRC_USB_PACKED || sel == SRC_I2S_PACKED) begin
			return (sel == act && !mute) ? pk : '0;
		end
		return lv;
	endfunction

	// register state
	logic [31:0]          route_q;
	logic                 res24_q;
	logic                 cfg_done_q;
	logic [ERRCNT_W-1:0]  err_cnt_q;
	logic                 wr_pend_q;
	logic [ADDR_W-1:0]    wr_addr_q;
	logic [31:0]          hrdata_q;
	logic [31:0]          rd_mux;
	logic                 acc;
	logic                 cnt_clr;
	// deframer state
	sync_state_t          state_q;
	logic [1:0]           phase_q;
	logic [SRC_W-1:0]     act_src;
	logic [SRC_W-1:0]     src_q;
	logic                 two_ch_q;
	quad_t                cap_q;
	quad_t                pk;
	logic                 muted;
	// fifo and stream mux
	frame_t               in_frame;
	frame_t               f_data;
	logic                 f_in_valid;
	logic                 f_in_ready;
	logic                 f_valid;
	logic                 pop;
	logic [1:0]           marks;
	logic                 mark_ok;
	logic                 err_evt;
	logic                 resync;
	logic                 packed_done;
	logic [4:0]           usb_pos;
	// output stage
	quad_t                out_q;
	logic                 out_valid_q;
	logic                 slot_free;
	logic                 injecting;
	logic                 load;
	logic [SRC_W-1:0]     sel [4];
	// ahb-lite slave: zero wait states, always okay

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign acc       = hsel && htrans[1] && hready;
	assign cnt_clr   = wr_pend_q && wr_addr_q == ADDR_STATUS;

	// status word shows the deframer's own state
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr[ADDR_W-1:0] == ADDR_ROUTE) begin
			rd_mux = route_q;
		end else if (haddr[ADDR_W-1:0] == ADDR_STATUS) begin
			rd_mux[ST_RES24_BIT]  = res24_q;
			rd_mux[ST_LOCK_BIT]   = state_q == ST_RUN;
			rd_mux[ST_MUTE_BIT]   = muted;
			rd_mux[ST_TWO_CH_BIT] = two_ch_q;
			rd_mux[ST_ERRCNT_LSB +: ERRCNT_W] = err_cnt_q;
		end
	end

	// address phase captured; write data lands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q  <= 32'h0000_0000;
		end else begin
			wr_pend_q <= acc && hwrite;
			if (acc) begin
				wr_addr_q <= haddr[ADDR_W-1:0];
			end
			hrdata_q <= (acc && !hwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// routing is live: a write takes effect on the next frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			route_q <= ROUTE_RST;
		end else if (wr_pend_q && wr_addr_q == ADDR_ROUTE) begin
			route_q <= hwdata;
		end
	end

	// write to status clears the error count; a same-cycle error still counts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_cnt_q <= '0;
		end else if (err_evt && (cnt_clr || err_cnt_q != '1)) begin
			err_cnt_q <= cnt_clr ? ERRCNT_W'(1) : err_cnt_q + 1'b1;
		end else if (cnt_clr) begin
			err_cnt_q <= '0;
		end
	end

	// resolution is caught once after reset and never rewritten
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res24_q    <= 1'b0;
			cfg_done_q <= 1'b0;
		end else if (!cfg_done_q) begin
			res24_q    <= cfg_usb_res24;
			cfg_done_q <= 1'b1;
		end
	end

	// source selection and stream normalisation

	// destinations 4..7 sit in byte lanes 0..3 of the route word
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			sel[i] = route_q[i*ROUTE_LANE_W +: SRC_W];
		end
	end

	// usb wins if both packed sources appear; the other stays silent
	always_comb begin
		act_src = '0;
		for (int i = 3; i >= 0; i--) begin
			if (sel[i] == SRC_USB_PACKED) begin
				act_src = SRC_USB_PACKED;
			end
		end
		if (act_src == '0) begin
			for (int i = 0; i < 4; i++) begin
				if (sel[i] == SRC_I2S_PACKED) begin
					act_src = SRC_I2S_PACKED;
				end
			end
		end
	end

	assign injecting = act_src != '0;
	assign usb_pos   = res24_q ? MARK_POS_USB24 : MARK_POS_USB16;

	// marker is split off the lowest audio bit; audio keeps the rest
	always_comb begin
		in_frame   = '0;
		f_in_valid = 1'b0;
		usb_ready  = 1'b1;
		i2s_ready  = 1'b1;
		if (act_src == SRC_USB_PACKED && cfg_done_q) begin
			in_frame.left   = strip(usb_word(usb_left, res24_q), usb_pos);
			in_frame.right  = strip(usb_word(usb_right, res24_q), usb_pos);
			in_frame.mark_l = usb_left[usb_pos - 5'h08]; // word sits eight bits up
			in_frame.mark_r = usb_right[usb_pos - 5'h08];
			f_in_valid      = usb_valid;
			usb_ready       = f_in_ready;
		end else if (act_src == SRC_I2S_PACKED) begin
			in_frame.left   = strip(i2s_left, MARK_POS_I2S);
			in_frame.right  = strip(i2s_right, MARK_POS_I2S);
			in_frame.mark_l = i2s_left[MARK_POS_I2S];
			in_frame.mark_r = i2s_right[MARK_POS_I2S];
			f_in_valid      = i2s_valid;
			i2s_ready       = f_in_ready;
		end
	end

	// eight frames of slack absorb host jitter; full fifo stalls the source
	frame_fifo #(
		.WIDTH ($bits(frame_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (in_frame),
		.out_valid (f_valid),
		.out_ready (slot_free),
		.out_data  (f_data)
	);

	// deframer: three 48 kHz frames per 16 kHz slot

	assign pop    = f_valid && slot_free;
	assign marks  = {f_data.mark_l, f_data.mark_r};
	assign resync = act_src != src_q;

	// expected marker per phase; last phase right bit flags two channels
	always_comb begin
		case (phase_q)
			2'd0:    mark_ok = marks == MARK_START;
			2'd1:    mark_ok = marks == MARK_MID;
			2'd2:    mark_ok = !f_data.mark_l;
			default: mark_ok = 1'b0;
		endcase
	end

	assign err_evt     = pop && !resync && state_q != ST_HUNT && !mark_ok;
	assign packed_done = pop && !resync && state_q == ST_RUN && mark_ok
		&& phase_q == LAST_PHASE;
	assign muted       = state_q != ST_RUN;

	// alignment state; any error drops back and a full sequence must pass again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_HUNT;
			phase_q <= 2'd0;
			src_q   <= '0;
		end else begin
			src_q <= act_src;
			if (resync) begin
				state_q <= ST_HUNT; // route change restarts alignment
				phase_q <= 2'd0;
			end else if (pop) begin
				case (state_q)
					ST_HUNT: begin
						if (marks == MARK_START) begin
							state_q <= ST_ALIGN;
							phase_q <= 2'd1;
						end
					end
					ST_ALIGN, ST_RUN: begin
						if (!mark_ok) begin
							// a start marker here realigns at once
							state_q <= (marks == MARK_START) ? ST_ALIGN : ST_HUNT;
							phase_q <= (marks == MARK_START) ? 2'd1 : 2'd0;
						end else if (phase_q == LAST_PHASE) begin
							state_q <= ST_RUN;
							phase_q <= 2'd0;
						end else begin
							phase_q <= phase_q + 2'd1;
						end
					end
					default: begin
						state_q <= ST_HUNT;
						phase_q <= 2'd0;
					end
				endcase
			end
		end
	end

	// phase 0 carries channel a of mic and ref, phase 1 channel b
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_q <= '0;
		end else if (pop && mark_ok) begin
			if (phase_q == 2'd0) begin
				cap_q.mic_a <= f_data.left;
				cap_q.ref_a <= f_data.right;
			end else if (phase_q == 2'd1) begin
				cap_q.mic_b <= f_data.left;
				cap_q.ref_b <= f_data.right;
			end
		end
	end

	// two-channel flag follows each slot completed in the ST_RUN state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			two_ch_q <= 1'b0;
		end else if (packed_done) begin
			two_ch_q <= f_data.mark_r;
		end
	end

	// refs forced to zero for a two-channel vector
	assign pk = f_data.mark_r ? {cap_q.mic_a, cap_q.mic_b, {2*SAMPLE_W{1'b0}}} : cap_q;

	// output stage toward the pipeline front

	assign slot_free  = !out_valid_q || pipe_ready;
	assign live_ready = slot_free;

	// while injecting, the packed stream paces the pipeline; when muted the
	// live tick keeps zeros flowing so the pipeline never starves
	assign load = slot_free && (injecting
		? (packed_done || (muted && live_valid))
		: live_valid);

	// each destination takes packed, zero or live data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_q <= '0;
		end else if (load) begin
			out_q.mic_a <= pick(sel[0], act_src, muted, pk.mic_a, live_in.mic_a);
			out_q.mic_b <= pick(sel[1], act_src, muted, pk.mic_b, live_in.mic_b);
			out_q.ref_a <= pick(sel[2], act_src, muted, pk.ref_a, live_in.ref_a);
			out_q.ref_b <= pick(sel[3], act_src, muted, pk.ref_b, live_in.ref_b);
		end
	end

	// valid holds until the pipeline accepts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_valid_q <= 1'b0;
		end else if (load) begin
			out_valid_q <= 1'b1;
		end else if (pipe_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	assign pipe_valid           = out_valid_q;
	assign pipeline_mic_input_a = out_q.mic_a;
	assign pipeline_mic_input_b = out_q.mic_b;
	assign pipeline_ref_input_a = out_q.ref_a;
	assign pipeline_ref_input_b = out_q.ref_b;

endmodule

// file: dv/deframer_sva.sv
module deframer_sva
	import deframer_pkg::*;
(
	// clock and reset
	input wire logic                hclk,
	input wire logic                hresetn,
	// register bus
	input wire logic                hsel,
	input wire logic [31:0]         haddr,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic [31:0]         hwdata,
	input wire logic                hready,
	input wire logic                hreadyout,
	input wire logic                hresp,
	input wire logic [31:0]         hrdata,
	// streams
	input wire logic                usb_valid,
	input wire logic                usb_ready,
	input wire logic                live_valid,
	input wire logic                live_ready,
	input wire quad_t               live_in,
	input wire logic                pipe_valid,
	input wire logic                pipe_ready,
	input wire logic [SAMPLE_W-1:0] pipeline_mic_input_a,
	input wire logic [SAMPLE_W-1:0] pipeline_ref_input_b
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	localparam logic [31:0] LANES = 32'h1F1F_1F1F;
	logic        rd_q;
	logic        wr_q;
	logic [7:0]  a_q;
	logic [31:0] route_q;
	wire         take = hsel && htrans[1] && hready;
	wire         usb_on = route_q[4:0] == SRC_USB_PACKED || route_q[12:8] == SRC_USB_PACKED
		|| route_q[20:16] == SRC_USB_PACKED || route_q[28:24] == SRC_USB_PACKED;
	// shadow of the bus one data phase behind, so routing is known without peeking inside
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'h0;
			wr_q <= 1'h0;
			a_q <= 8'h00;
		end else begin
			rd_q <= take && !hwrite;
			wr_q <= take && hwrite;
			a_q <= haddr[7:0];
		end
	end
	// route mirror
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			route_q <= ROUTE_RST;
		end else if (wr_q && a_q == ADDR_ROUTE) begin
			route_q <= hwdata;
		end
	end
	AST_ZERO_WAIT: assert property (hreadyout && !hresp)
		else $error("bus did not answer at once with okay");
	AST_RD_IDLE: assert property (!rd_q |-> hrdata == 32'h0)
		else $error("read data outside a read data phase");
	AST_UNMAPPED: assert property (take && !hwrite && haddr[7:0] > 8'h07 |=> hrdata == 32'h0)
		else $error("unmapped read gave data");
	AST_ROUTE_RB: assert property (take && !hwrite && haddr[7:0] == ADDR_ROUTE
		|=> (hrdata & LANES) == (route_q & LANES))
		else $error("route read back differs from last write");
	AST_LIVE_RDY: assert property (live_ready == (!pipe_valid || pipe_ready))
		else $error("live ready wrong");
	AST_PIPE_HOLD: assert property (pipe_valid && !pipe_ready
		|=> pipe_valid && $stable(pipeline_mic_input_a) && $stable(pipeline_ref_input_b))
		else $error("pipeline output moved while stalled");
	AST_LIVE_LAT: assert property (route_q == 32'h0 && live_valid && live_ready
		|=> pipe_valid && pipeline_mic_input_a == $past(live_in.mic_a)
		&& pipeline_ref_input_b == $past(live_in.ref_b))
		else $error("live sample not passed in one cycle");
	AST_USB_DISCARD: assert property (!usb_on |-> usb_ready)
		else $error("unselected usb stream stalled");
	COV_PIPE: cover property (pipe_valid && pipe_ready);
	COV_USB: cover property (usb_valid && usb_ready);
	COV_STATUS: cover property (take && !hwrite && haddr[7:0] == ADDR_STATUS);
endmodule

bind packed_audio_injection_deframer deframer_sva u_sva (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .usb_valid(usb_valid), .usb_ready(usb_ready),
	.live_valid(live_valid), .live_ready(live_ready), .live_in(live_in),
	.pipe_valid(pipe_valid), .pipe_ready(pipe_ready),
	.pipeline_mic_input_a(pipeline_mic_input_a), .pipeline_ref_input_b(pipeline_ref_input_b)
);

// file: dv/host_source.sv
module host_source #(
	parameter int unsigned W = 24
) (
	// clock
	input wire logic   hclk,
	// one idle cycle after each frame when set
	input wire logic   slow,
	// stream towards the device
	input wire logic   ready,
	output logic       valid,
	output logic [W-1:0] left,
	output logic [W-1:0] right
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2*W-1:0] q[$];
	initial begin
		valid = 1'h0;
		left = '0;
		right = '0;
	end
	// frames leave whole, unscaled and in order; idle lines invert so stale data cannot match
	always @(posedge hclk) begin
		if (valid && ready) begin
			void'(q.pop_front());
		end
		if (!(valid && !ready)) begin
			if (q.size() != 0 && !(slow && valid)) begin
				valid <= 1'h1;
				{left, right} <= q[0];
			end else begin
				valid <= 1'h0;
				left <= ~left;
				right <= ~right;
			end
		end
	end
endmodule

// file: dv/tb.sv
module tb;
	import deframer_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam quad_t Q1 = 128'h89AB_CDEF_0123_4567_FEDC_BA98_7654_3211;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel = 1'h0;
	logic        hwrite = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        cfg = 1'h1;
	logic        slow = 1'h0;
	logic        live_valid = 1'h0;
	logic        pipe_ready = 1'h1;
	quad_t       live_in = '0;
	quad_t       got_q = '0;
	logic [31:0] v;
	int          err_total = 0;
	int          tests_run = 0;
	int          n_exp = 0;
	int          n_out = 0;
	wire hready, hreadyout, hresp, usb_ready, usb_valid, i2s_ready, i2s_valid;
	wire live_ready, pipe_valid;
	wire [31:0] hrdata, i2s_left, i2s_right, mic_a, mic_b, ref_a, ref_b;
	wire [USB_W-1:0] usb_left, usb_right;

	always #20 hclk = ~hclk;
	assign hready = hreadyout;

	packed_audio_injection_deframer u_packed_audio_injection_deframer (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfg_usb_res24(cfg),
		.usb_valid(usb_valid), .usb_ready(usb_ready), .usb_left(usb_left),
		.usb_right(usb_right), .i2s_valid(i2s_valid), .i2s_ready(i2s_ready),
		.i2s_left(i2s_left), .i2s_right(i2s_right), .live_valid(live_valid),
		.live_ready(live_ready), .live_in(live_in), .pipe_valid(pipe_valid),
		.pipe_ready(pipe_ready), .pipeline_mic_input_a(mic_a), .pipeline_mic_input_b(mic_b),
		.pipeline_ref_input_a(ref_a), .pipeline_ref_input_b(ref_b));
	host_source #(.W(USB_W)) u_usb (.hclk(hclk), .slow(1'h0), .ready(usb_ready),
		.valid(usb_valid), .left(usb_left), .right(usb_right));
	host_source #(.W(SAMPLE_W)) u_i2s (.hclk(hclk), .slow(slow), .ready(i2s_ready),
		.valid(i2s_valid), .left(i2s_left), .right(i2s_right));

	// pipeline side capture
	always @(posedge hclk) begin
		if (pipe_valid === 1'h1 && pipe_ready) begin
			got_q <= {mic_a, mic_b, ref_a, ref_b};
			n_out <= n_out + 1;
		end
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	// single word transfer; read data lands in v
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		v = hrdata;
	endtask

	task automatic live_one(input quad_t x);
		@(posedge hclk);
		live_valid <= 1'h1;
		live_in <= x;
		do @(posedge hclk); while (live_ready !== 1'h1);
		live_valid <= 1'h0;
		live_in <= ~x;
	endtask

	function automatic logic [31:0] aud(input logic s, input logic [31:0] x);
		return s ? {x[31:1], 1'h0} : {x[31:9], 9'h000};
	endfunction

	function automatic quad_t exq(input logic s, input quad_t x, input logic two);
		return {aud(s, x.mic_a), aud(s, x.mic_b), two ? 64'h0 : {aud(s, x.ref_a), aud(s, x.ref_b)}};
	endfunction

	// one 16 kHz slot as three marked frames; queue is filled off the sampling edge
	task automatic trip(input logic s, input quad_t x, input logic two);
		@(negedge hclk);
		if (s) begin
			u_i2s.q.push_back({x.mic_a[31:1], 1'h1, x.ref_a[31:1], 1'h1});
			u_i2s.q.push_back({x.mic_b[31:1], 1'h0, x.ref_b[31:1], 1'h0});
			u_i2s.q.push_back({63'h0, two});
		end else begin
			u_usb.q.push_back({x.mic_a[31:9], 1'h1, x.ref_a[31:9], 1'h1});
			u_usb.q.push_back({x.mic_b[31:9], 1'h0, x.ref_b[31:9], 1'h0});
			u_usb.q.push_back({47'h0, two});
		end
	endtask

	task automatic wait_out(input int k);
		n_exp += k;
		repeat (400) if (n_out < n_exp) @(posedge hclk);
		chk(n_out, n_exp);
	endtask

	// let queued frames drain through the fifo
	task automatic settle();
		repeat (400) if (u_usb.q.size() + u_i2s.q.size() != 0) @(posedge hclk);
		repeat (6) @(posedge hclk);
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		#1ms;
		err_total++;
		$display("unexpected at %0t ns: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		cfg <= 1'h0; // only the start-up value may count
		ahb(0, ADDR_ROUTE, 32'h0);
		chk(v, ROUTE_RST);
		ahb(0, 8'h40, 32'h0);
		chk(v, 32'h0);
		ahb(1, ADDR_STATUS, 32'hFFFF_FFFF);
		ahb(0, ADDR_STATUS, 32'h0);
		chk(v[ST_RES24_BIT], 1'h1);
		chk(v[ST_LOCK_BIT], 1'h0);
		live_one(Q1);
		wait_out(1);
		chk(got_q, Q1);
		$display("test reset and live done");
		// usb injection: first slot aligns, later slots are delivered
		ahb(1, ADDR_ROUTE, 32'h1111_1111);
		for (int k = 0; k < 3; k++) trip(0, Q1 ^ {16{8'(k)}}, 1'h0);
		wait_out(2);
		chk(got_q, exq(0, Q1 ^ {16{8'h02}}, 1'h0));
		trip(0, Q1, 1'h1);
		wait_out(1);
		chk(got_q, exq(0, Q1, 1'h1));
		ahb(0, ADDR_STATUS, 32'h0);
		chk(v[3:1], 3'h5);
		$display("test usb injection done");
		// broken marker mutes until a fresh slot has been aligned again
		@(negedge hclk);
		u_usb.q.push_back({24'h0, 24'h1});
		settle();
		ahb(0, ADDR_STATUS, 32'h0);
		chk(v[ST_ERRCNT_LSB +: ERRCNT_W], 8'h01);
		chk(v[ST_MUTE_BIT], 1'h1);
		live_one(Q1);
		wait_out(1);
		chk(got_q, 128'h0);
		trip(0, Q1, 1'h0);
		settle();
		ahb(0, ADDR_STATUS, 32'h0);
		chk(v[ST_MUTE_BIT], 1'h0);
		chk(n_out, n_exp);
		trip(0, ~Q1, 1'h0);
		wait_out(1);
		chk(got_q, exq(0, ~Q1, 1'h0));
		ahb(1, ADDR_STATUS, 32'h0);
		ahb(0, ADDR_STATUS, 32'h0);
		chk(v[ST_ERRCNT_LSB +: ERRCNT_W], 8'h00);
		$display("test marker error done");
		// switch to i2s while running, with a slow host
		slow <= 1'h1;
		ahb(1, ADDR_ROUTE, 32'h1212_1212);
		trip(1, Q1, 1'h0);
		trip(1, ~Q1, 1'h0);
		wait_out(1);
		chk(got_q, exq(1, ~Q1, 1'h0));
		chk(usb_ready, 1'h1);
		$display("test i2s injection done");
		// stall the pipeline until the buffer refuses, then drain it
		pipe_ready <= 1'h0;
		for (int k = 0; k < 6; k++) trip(1, Q1 ^ {16{8'(k)}}, 1'h0);
		repeat (400) if (i2s_ready === 1'h1) @(posedge hclk);
		chk(i2s_ready, 1'h0);
		pipe_ready <= 1'h1;
		wait_out(6);
		chk(got_q, exq(1, Q1 ^ {16{8'h05}}, 1'h0));
		$display("test buffer fill done");
		end_of_test();
	end
endmodule
